// File: include/mbr_cfg.svh
// Constants of the sensor readout link and the logger register map.
// Assumes a 50 MHz hclk shared by both ends of the link.
`ifndef MBR_CFG_SVH
`define MBR_CFG_SVH

// Timing
`define MBR_CLK_HZ        50_000_000
`define MBR_BAUD          19_200
`define MBR_BIT_CYC       (`MBR_CLK_HZ / `MBR_BAUD)
`define MBR_HALF_CYC      (`MBR_BIT_CYC / 2)
`define MBR_CHAR_BITS     11
`define MBR_SILENCE_CYC   (`MBR_BIT_CYC * `MBR_CHAR_BITS * 7 / 2)
`define MBR_TIMEOUT_MS    1000
`define MBR_TIMEOUT_CYC   (`MBR_CLK_HZ / 1000 * `MBR_TIMEOUT_MS)

// Protocol
`define MBR_FN_READ_INPUT 8'h04
`define MBR_EXC_FLAG      8'h80
`define MBR_EXC_FUNC      8'h01
`define MBR_EXC_VALUE     8'h03
`define MBR_MAX_REGS      16'h007D
`define MBR_CRC_INIT      16'hFFFF
`define MBR_CRC_POLY      16'hA001

// Sensor input register numbers
`define MBR_REG_STATION   16'h0001
`define MBR_REG_IRR_COMP  16'h0003
`define MBR_REG_IRR_RAW   16'h0005
`define MBR_REG_BODY_TEMP 16'h0007
`define MBR_REG_RESIST    16'h0008
`define MBR_REG_IRR_SCALE 16'h0009
`define MBR_REG_TMP_SCALE 16'h000A
`define MBR_REG_VOLTAGE   16'h000B
`define MBR_REG_SERIAL    16'h0029
`define MBR_REG_SENSITIV  16'h002A
`define MBR_REG_CAL_DATE  16'h002F
`define MBR_REG_HUMIDITY  16'h0063

// Logger register offsets and fields
`define MBR_CMD_OFS       8'h00
`define MBR_STAT_OFS      8'h04
`define MBR_DATA_OFS      8'h08
`define MBR_CMD_ADDR_LSB  16
`define MBR_CMD_PAIR_BIT  24
`define MBR_CMD_RESET     25'h000_0000
`define MBR_DATA_RESET    32'h0000_0000

`endif

// File: include/mbr_pkg.sv
// Types and the frame check shared by both ends of the link.
// Assumes mbr_cfg.svh on the include path.
`include "mbr_cfg.svh"
package mbr_pkg;
   typedef enum logic [1:0] {
      DEV_LISTEN = 2'b01,
      DEV_REPLY  = 2'b10
   } mbr_dev_state_e;

   typedef enum logic [2:0] {
      HST_IDLE = 3'b001,
      HST_SEND = 3'b010,
      HST_WAIT = 3'b100
   } mbr_host_state_e;

   function automatic logic [15:0] mbr_crc_byte(input logic [15:0] crc,
                                                input logic [7:0]  b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ `MBR_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
endpackage

// File: include/mbr_link_if.sv
// Two-wire half-duplex pair between logger and sensor.
// Assumes each end drives only while its enable is high.
`timescale 1ns/1ps
interface mbr_link_if;
   logic m_tx;
   logic m_de;
   logic s_tx;
   logic s_de;
   logic line;

   // Fail-safe bias holds the idle pair at mark
   assign line = (m_de ? m_tx : 1'b1) & (s_de ? s_tx : 1'b1);

   modport master (output m_tx, output m_de, input line);
   modport slave  (output s_tx, output s_de, input line);
endinterface

// File: src/mbr_sensor_slave.sv
// Sensor end: RTU slave serving measured values as input registers.
// Assumes measured values are stable in hclk and the link is synchronous.
//
// Contract
// - Link runs 19200 baud, 8E1 characters.
// - Half-duplex: never drive pair with partner.
// - Serve values as RTU input registers.
// - Answer only frames addressed to this station number.
// - Master asks one or two registers.
// - Sixteen-bit values at their register numbers.
// - Irradiance pairs at registers 3 and 5.
// - Voltage at 11, calibration date at 47.
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module mbr_sensor_slave #(
   parameter int SILENCE_CYC = `MBR_SILENCE_CYC,
   parameter int BIT_CYC     = `MBR_BIT_CYC
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Link
   mbr_link_if.slave        link,
   // Configured address
   input  wire logic [7:0]  station_number,
   // Measured values
   input  wire logic [31:0] irradiance_compensated,
   input  wire logic [31:0] irradiance_raw,
   input  wire logic [15:0] body_temperature,
   input  wire logic [15:0] element_resistance,
   input  wire logic [15:0] irradiance_scale,
   input  wire logic [15:0] temperature_scale,
   input  wire logic [31:0] element_voltage,
   input  wire logic [15:0] unit_serial,
   input  wire logic [31:0] element_sensitivity,
   input  wire logic [31:0] calibration_date,
   input  wire logic [15:0] internal_humidity,
   // Status
   output logic             served
);
   localparam logic [11:0] BIT_LAST  = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_LAST = 12'(BIT_CYC / 2 - 1);
   localparam logic [31:0] SIL_LAST  = 32'(SILENCE_CYC - 1);

   mbr_pkg::mbr_dev_state_e state;
   logic [11:0] rx_cnt;
   logic [3:0]  rx_idx;
   logic        rx_busy;
   logic [10:0] rx_sh;
   logic [31:0] sil;
   logic [7:0]  rq [0:7];
   logic [3:0]  rq_n;
   logic        rq_bad;
   logic [15:0] rq_crc;
   logic [7:0]  rsp_k;
   logic [7:0]  rsp_n;
   logic [7:0]  exc;
   logic [15:0] tx_crc;
   logic [11:0] tx_cnt;
   logic [3:0]  tx_idx;
   logic        tx_busy;
   logic [10:0] tx_sh;
   logic        de;
   logic [15:0] word;
   logic [7:0]  tx_byte;

   // Receive decode
   wire        listen    = (state == mbr_pkg::DEV_LISTEN);
   wire        rx_tick   = rx_busy && (rx_cnt == 12'h000);
   wire [10:0] rx_full   = {link.line, rx_sh[10:1]};
   wire        rx_done   = rx_tick && (rx_idx == 4'hA);
   wire        rx_ok     = !rx_full[0] && rx_full[10] && !(^rx_full[9:1]);
   wire        rx_start  = listen && !rx_busy && !link.line;
   wire        frame_end = listen && (sil == SIL_LAST) && (rq_n != 4'h0);

   // Request decode
   wire [15:0] rq_start  = {rq[2], rq[3]};
   wire [15:0] rq_cnt    = {rq[4], rq[5]};
   wire        addr_hit  = (rq[0] == station_number);
   wire        accept    = frame_end && (rq_n == 4'h8) && !rq_bad &&
                           (rq_crc == 16'h0000) && addr_hit;
   wire        bad_fn    = (rq[1] != `MBR_FN_READ_INPUT);
   wire        bad_cnt   = (rq_cnt == 16'h0000) || (rq_cnt > `MBR_MAX_REGS);
   wire [7:0]  next_exc  = bad_fn ? `MBR_EXC_FUNC :
                           (bad_cnt ? `MBR_EXC_VALUE : 8'h00);
   wire [7:0]  next_rsp_n = (next_exc != 8'h00) ? 8'h05 :
                            (8'h05 + {rq_cnt[6:0], 1'b0});

   // Reply decode
   wire        in_reply   = (state == mbr_pkg::DEV_REPLY);
   wire        tx_load    = in_reply && !tx_busy && (rsp_k != rsp_n);
   wire        reply_done = in_reply && !tx_busy && (rsp_k == rsp_n);
   wire [7:0]  data_k     = rsp_k - 8'h03;
   wire [15:0] reg_n      = rq_start + {9'h000, data_k[7:1]};
   wire [7:0]  data_b     = data_k[0] ? word[7:0] : word[15:8];
   wire [7:0]  fn_b       = (exc != 8'h00) ? (rq[1] | `MBR_EXC_FLAG) : rq[1];
   wire [7:0]  cnt_b      = (exc != 8'h00) ? exc : {rq_cnt[6:0], 1'b0};

   // Input register map; unmapped numbers read as zero
   always_comb begin
      case (reg_n)
         `MBR_REG_STATION:   word = {8'h00, station_number};
         `MBR_REG_IRR_COMP:  word = irradiance_compensated[31:16];
         `MBR_REG_IRR_COMP + 16'h0001:
                             word = irradiance_compensated[15:0];
         `MBR_REG_IRR_RAW:   word = irradiance_raw[31:16];
         `MBR_REG_IRR_RAW + 16'h0001:
                             word = irradiance_raw[15:0];
         `MBR_REG_BODY_TEMP: word = body_temperature;
         `MBR_REG_RESIST:    word = element_resistance;
         `MBR_REG_IRR_SCALE: word = irradiance_scale;
         `MBR_REG_TMP_SCALE: word = temperature_scale;
         `MBR_REG_VOLTAGE:   word = element_voltage[31:16];
         `MBR_REG_VOLTAGE + 16'h0001:
                             word = element_voltage[15:0];
         `MBR_REG_SERIAL:    word = unit_serial;
         `MBR_REG_SENSITIV:  word = element_sensitivity[31:16];
         `MBR_REG_SENSITIV + 16'h0001:
                             word = element_sensitivity[15:0];
         `MBR_REG_CAL_DATE:  word = calibration_date[31:16];
         `MBR_REG_CAL_DATE + 16'h0001:
                             word = calibration_date[15:0];
         `MBR_REG_HUMIDITY:  word = internal_humidity;
         default:            word = 16'h0000;
      endcase
   end

   // Frame layout of the reply, check bytes last
   always_comb begin
      if (rsp_k == rsp_n - 8'h02) begin
         tx_byte = tx_crc[7:0];
      end else if (rsp_k == rsp_n - 8'h01) begin
         tx_byte = tx_crc[15:8];
      end else begin
         case (rsp_k)
            8'h00:   tx_byte = station_number;
            8'h01:   tx_byte = fn_b;
            8'h02:   tx_byte = cnt_b;
            default: tx_byte = data_b;
         endcase
      end
   end

   // Character receiver, sampled mid-bit; ignores own transmission
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_busy <= 1'b0;
         rx_cnt  <= 12'h000;
         rx_idx  <= 4'h0;
         rx_sh   <= 11'h7FF;
      end else if (rx_start) begin
         rx_busy <= 1'b1;
         rx_cnt  <= HALF_LAST;
         rx_idx  <= 4'h0;
      end else if (rx_tick) begin
         rx_sh   <= rx_full;
         rx_cnt  <= BIT_LAST;
         rx_idx  <= rx_idx + 4'h1;
         if ((rx_idx == 4'hA) || ((rx_idx == 4'h0) && link.line)) begin
            rx_busy <= 1'b0;
         end
      end else if (rx_busy) begin
         rx_cnt <= rx_cnt - 12'h001;
      end
   end

   // Idle-line timer closes a request frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sil <= 32'h0000_0000;
      end else if (!listen || rx_busy || !link.line) begin
         sil <= 32'h0000_0000;
      end else if (sil != SIL_LAST) begin
         sil <= sil + 32'h0000_0001;
      end
   end

   // Request bytes; no reset needed on the byte store
   always_ff @(posedge hclk) begin
      if (rx_done && (rq_n < 4'h8)) begin
         rq[rq_n[2:0]] <= rx_full[8:1];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rq_n   <= 4'h0;
         rq_bad <= 1'b0;
         rq_crc <= `MBR_CRC_INIT;
      end else if (frame_end) begin
         rq_n   <= 4'h0;
         rq_bad <= 1'b0;
         rq_crc <= `MBR_CRC_INIT;
      end else if (rx_done) begin
         if (rq_n != 4'hF) begin
            rq_n <= rq_n + 4'h1;
         end
         rq_bad <= rq_bad | !rx_ok;
         rq_crc <= mbr_pkg::mbr_crc_byte(rq_crc, rx_full[8:1]);
      end
   end

   // Reply sequencing; other stations' frames leave the pair alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state  <= mbr_pkg::DEV_LISTEN;
         rsp_k  <= 8'h00;
         rsp_n  <= 8'h00;
         exc    <= 8'h00;
         tx_crc <= `MBR_CRC_INIT;
         de     <= 1'b0;
         served <= 1'b0;
      end else begin
         served <= 1'b0;
         case (state)
            mbr_pkg::DEV_LISTEN: begin
               if (accept) begin
                  state  <= mbr_pkg::DEV_REPLY;
                  rsp_k  <= 8'h00;
                  rsp_n  <= next_rsp_n;
                  exc    <= next_exc;
                  tx_crc <= `MBR_CRC_INIT;
                  de     <= 1'b1;
               end
            end
            mbr_pkg::DEV_REPLY: begin
               if (tx_load) begin
                  rsp_k  <= rsp_k + 8'h01;
                  if (rsp_k < rsp_n - 8'h02) begin
                     tx_crc <= mbr_pkg::mbr_crc_byte(tx_crc, tx_byte);
                  end
               end else if (reply_done) begin
                  state  <= mbr_pkg::DEV_LISTEN;
                  de     <= 1'b0;
                  served <= (exc == 8'h00);
               end
            end
            default: begin
               state <= mbr_pkg::DEV_LISTEN;
               de    <= 1'b0;
            end
         endcase
      end
   end

   // Character transmitter: start, eight data LSB first, even parity, stop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_busy <= 1'b0;
         tx_sh   <= 11'h7FF;
         tx_cnt  <= 12'h000;
         tx_idx  <= 4'h0;
      end else if (tx_load) begin
         tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
         tx_cnt  <= BIT_LAST;
         tx_idx  <= 4'h0;
         tx_busy <= 1'b1;
      end else if (tx_busy) begin
         if (tx_cnt != 12'h000) begin
            tx_cnt <= tx_cnt - 12'h001;
         end else begin
            tx_cnt <= BIT_LAST;
            if (tx_idx == 4'hA) begin
               tx_busy <= 1'b0;
            end else begin
               tx_sh  <= {1'b1, tx_sh[10:1]};
               tx_idx <= tx_idx + 4'h1;
            end
         end
      end
   end

   assign link.s_tx = tx_sh[0];
   assign link.s_de = de;
endmodule

// File: src/mbr_logger_master.sv
// Logger end: RTU master reading one or two input registers per command.
// Assumes AHB-Lite single word transfers and a synchronous link.
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module mbr_logger_master #(
   parameter int SILENCE_CYC = `MBR_SILENCE_CYC,
   parameter int BIT_CYC     = `MBR_BIT_CYC,
   parameter int TIMEOUT_CYC = `MBR_TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Link
   mbr_link_if.master       link
);
   localparam logic [11:0] BIT_LAST  = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_LAST = 12'(BIT_CYC / 2 - 1);
   localparam logic [31:0] SIL_LAST  = 32'(SILENCE_CYC - 1);
   localparam logic [31:0] TMO_LAST  = 32'(TIMEOUT_CYC - 1);

   mbr_pkg::mbr_host_state_e state;
   logic        wr_pend;
   logic [7:0]  wr_ofs;
   logic [24:0] cmd;
   logic        done, err, excf;
   logic [7:0]  exc_code;
   logic [31:0] result;
   logic [11:0] rx_cnt, tx_cnt;
   logic [3:0]  rx_idx, tx_idx, rs_n, tx_k;
   logic        rx_busy, tx_busy, de, rs_bad;
   logic [10:0] rx_sh, tx_sh;
   logic [31:0] sil, tmo;
   logic [7:0]  rs [0:8];
   logic [15:0] rs_crc, tx_crc;
   logic [7:0]  tx_byte;

   // Bus decode
   wire        bus_go   = hsel && htrans[1] && hready;
   wire [7:0]  slave_ad = cmd[`MBR_CMD_ADDR_LSB +: 8];
   wire        pair     = cmd[`MBR_CMD_PAIR_BIT];
   wire [31:0] status   = {16'h0000, exc_code, 4'h0, excf, err, done,
                           (state != mbr_pkg::HST_IDLE)};
   wire [31:0] rd_mux   = (haddr[7:0] == `MBR_CMD_OFS)  ? {7'h00, cmd} :
                          (haddr[7:0] == `MBR_STAT_OFS) ? status :
                          (haddr[7:0] == `MBR_DATA_OFS) ? result :
                          32'h0000_0000;
   wire        go       = wr_pend && (wr_ofs == `MBR_CMD_OFS) &&
                          (state == mbr_pkg::HST_IDLE);

   // Link decode
   wire        listen   = (state == mbr_pkg::HST_WAIT);
   wire        rx_tick  = rx_busy && (rx_cnt == 12'h000);
   wire [10:0] rx_full  = {link.line, rx_sh[10:1]};
   wire        rx_done  = rx_tick && (rx_idx == 4'hA);
   wire        rx_start = listen && !rx_busy && !link.line;
   wire        f_end    = listen && (sil == SIL_LAST) && (rs_n != 4'h0);
   wire        t_out    = listen && (tmo == TMO_LAST) && (rs_n == 4'h0);
   wire        hdr_ok   = !rs_bad && (rs_crc == 16'h0000) &&
                          (rs[0] == slave_ad);
   wire        ok_data  = hdr_ok && (rs[1] == `MBR_FN_READ_INPUT) &&
                          (rs[2] == (pair ? 8'h04 : 8'h02)) &&
                          (rs_n == (pair ? 4'h9 : 4'h7));
   wire        ok_exc   = hdr_ok && (rs_n == 4'h5) &&
                          (rs[1] == (`MBR_FN_READ_INPUT | `MBR_EXC_FLAG));
   wire        tx_load  = (state == mbr_pkg::HST_SEND) && !tx_busy &&
                          (tx_k != 4'h8);
   wire        sent     = (state == mbr_pkg::HST_SEND) && !tx_busy &&
                          (tx_k == 4'h8);

   // Request frame: station, function, start, count, check
   always_comb begin
      case (tx_k)
         4'h0:    tx_byte = slave_ad;
         4'h1:    tx_byte = `MBR_FN_READ_INPUT;
         4'h2:    tx_byte = cmd[15:8];
         4'h3:    tx_byte = cmd[7:0];
         4'h4:    tx_byte = 8'h00;
         4'h5:    tx_byte = pair ? 8'h02 : 8'h01;
         4'h6:    tx_byte = tx_crc[7:0];
         default: tx_byte = tx_crc[15:8];
      endcase
   end

   // AHB-Lite slave, zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wr_pend   <= 1'b0;
         wr_ofs    <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= bus_go && hwrite;
         wr_ofs    <= haddr[7:0];
         if (bus_go && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Reply bytes
   always_ff @(posedge hclk) begin
      if (rx_done && (rs_n < 4'h9)) begin
         rs[rs_n] <= rx_full[8:1];
      end
   end

   // Receiver, idle timer and timeout; only while awaiting a reply
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_busy <= 1'b0;
         rx_cnt  <= 12'h000;
         rx_idx  <= 4'h0;
         rx_sh   <= 11'h7FF;
         sil     <= 32'h0000_0000;
         tmo     <= 32'h0000_0000;
      end else begin
         if (rx_start) begin
            rx_busy <= 1'b1;
            rx_cnt  <= HALF_LAST;
            rx_idx  <= 4'h0;
         end else if (rx_tick) begin
            rx_sh  <= rx_full;
            rx_cnt <= BIT_LAST;
            rx_idx <= rx_idx + 4'h1;
            if ((rx_idx == 4'hA) || ((rx_idx == 4'h0) && link.line)) begin
               rx_busy <= 1'b0;
            end
         end else if (rx_busy) begin
            rx_cnt <= rx_cnt - 12'h001;
         end
         sil <= (!listen || rx_busy || !link.line) ? 32'h0000_0000 :
                ((sil == SIL_LAST) ? sil : sil + 32'h0000_0001);
         tmo <= !listen ? 32'h0000_0000 :
                ((tmo == TMO_LAST) ? tmo : tmo + 32'h0000_0001);
      end
   end

   // Command sequencing and result capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state    <= mbr_pkg::HST_IDLE;
         cmd      <= `MBR_CMD_RESET;
         result   <= `MBR_DATA_RESET;
         done     <= 1'b0;
         err      <= 1'b0;
         excf     <= 1'b0;
         exc_code <= 8'h00;
         tx_k     <= 4'h0;
         tx_crc   <= `MBR_CRC_INIT;
         rs_n     <= 4'h0;
         rs_bad   <= 1'b0;
         rs_crc   <= `MBR_CRC_INIT;
         de       <= 1'b0;
      end else begin
         if (rx_done) begin
            rs_n   <= (rs_n == 4'hF) ? rs_n : rs_n + 4'h1;
            rs_bad <= rs_bad | rx_full[0] | !rx_full[10] | (^rx_full[9:1]);
            rs_crc <= mbr_pkg::mbr_crc_byte(rs_crc, rx_full[8:1]);
         end
         case (state)
            mbr_pkg::HST_IDLE: begin
               if (go) begin
                  state    <= mbr_pkg::HST_SEND;
                  cmd      <= hwdata[24:0];
                  done     <= 1'b0;
                  err      <= 1'b0;
                  excf     <= 1'b0;
                  exc_code <= 8'h00;
                  tx_k     <= 4'h0;
                  tx_crc   <= `MBR_CRC_INIT;
                  de       <= 1'b1;
               end
            end
            mbr_pkg::HST_SEND: begin
               if (tx_load) begin
                  tx_k   <= tx_k + 4'h1;
                  // Check bytes must stay out of their own sum
                  if (tx_k < 4'h6) begin
                     tx_crc <= mbr_pkg::mbr_crc_byte(tx_crc, tx_byte);
                  end
               end else if (sent) begin
                  state  <= mbr_pkg::HST_WAIT;
                  de     <= 1'b0;
                  rs_n   <= 4'h0;
                  rs_bad <= 1'b0;
                  rs_crc <= `MBR_CRC_INIT;
               end
            end
            mbr_pkg::HST_WAIT: begin
               if (f_end || t_out) begin
                  state    <= mbr_pkg::HST_IDLE;
                  done     <= 1'b1;
                  err      <= t_out || !(ok_data || ok_exc);
                  excf     <= f_end && ok_exc;
                  exc_code <= (f_end && ok_exc) ? rs[2] : 8'h00;
               end
               if (f_end && ok_data) begin
                  result <= pair ? {rs[3], rs[4], rs[5], rs[6]} :
                            {{16{rs[3][7]}}, rs[3], rs[4]};
               end
            end
            default: begin
               state <= mbr_pkg::HST_IDLE;
               de    <= 1'b0;
            end
         endcase
      end
   end

   // Transmitter, 8E1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_busy <= 1'b0;
         tx_sh   <= 11'h7FF;
         tx_cnt  <= 12'h000;
         tx_idx  <= 4'h0;
      end else if (tx_load) begin
         tx_sh   <= {1'b1, ^tx_byte, tx_byte, 1'b0};
         tx_cnt  <= BIT_LAST;
         tx_idx  <= 4'h0;
         tx_busy <= 1'b1;
      end else if (tx_busy) begin
         if (tx_cnt != 12'h000) begin
            tx_cnt <= tx_cnt - 12'h001;
         end else begin
            tx_cnt <= BIT_LAST;
            if (tx_idx == 4'hA) begin
               tx_busy <= 1'b0;
            end else begin
               tx_sh  <= {1'b1, tx_sh[10:1]};
               tx_idx <= tx_idx + 4'h1;
            end
         end
      end
   end

   assign link.m_tx = tx_sh[0];
   assign link.m_de = de;
endmodule

// File: bench/mbr_link_asserts.sv
// Link checks between logger and sensor ends.
// Assumes it sits beside the link interface.
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module mbr_link_asserts #(
   parameter int SILENCE_CYC = `MBR_SILENCE_CYC,
   parameter int BIT_CYC     = `MBR_BIT_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link
   input wire logic m_tx,
   input wire logic m_de,
   input wire logic s_tx,
   input wire logic s_de,
   input wire logic line
);
   localparam int BIT = BIT_CYC;
   int low_cnt;
   int high_cnt;
   // Run lengths, so bit timing needs no long repetition
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt  <= 0;
         high_cnt <= 0;
      end else begin
         low_cnt  <= line ? 0 : low_cnt + 1;
         high_cnt <= line ? high_cnt + 1 : 0;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence start_bit;
      !line [*8];
   endsequence
   sequence reply_start;
      ##[1:2] !line;
   endsequence
   chk_no_contention: assert property (!(m_de && s_de))
      else $error("both ends drive");
   chk_idle_mark: assert property (!m_de && !s_de |-> line)
      else $error("idle pair not mark");
   chk_master_idle: assert property (!m_de |-> m_tx)
      else $error("logger idle not mark");
   chk_slave_idle: assert property (!s_de |-> s_tx)
      else $error("sensor idle not mark");
   chk_start_low: assert property ($fell(line) |-> start_bit)
      else $error("start bit short");
   chk_bit_period: assert property ($rose(line) |-> low_cnt % BIT == 0)
      else $error("low run off bit grid");
   chk_turn_gap: assert property ($rose(s_de) |-> high_cnt >= SILENCE_CYC)
      else $error("reply before silence");
   chk_reply_start: assert property ($rose(s_de) |-> reply_start)
      else $error("reply start late");
   chk_master_drop: assert property ($fell(m_de) |-> $past(m_tx))
      else $error("logger drop mid bit");
   chk_slave_drop: assert property ($fell(s_de) |-> $past(s_tx))
      else $error("sensor drop mid bit");
endmodule

// File: bench/tb_modbus_irradiance_readout.sv
// Bench: logger and sensor joined, AHB-Lite commands, model compare.
// Assumes the design files and mbr_cfg.svh on the include path.
`timescale 1ns/1ps
`include "mbr_cfg.svh"
module tb_modbus_irradiance_readout;
   // Short bit time keeps the run small; framing is unchanged
   localparam int BIT = 26;
   localparam int SIL = 300;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout;
   logic        hresp, served;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, exp_d, lf;
   logic [31:0] v [12];
   logic [15:0] st [4] = '{`MBR_REG_IRR_COMP, `MBR_REG_VOLTAGE,
                           `MBR_REG_BODY_TEMP, `MBR_REG_HUMIDITY};
   logic        pr [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic [15:0] hi, lo;
   int          n_fail = 0, comparisons = 0, cyc = 0, n_srv = 0;
   mbr_link_if u_mbr_link_if ();
   mbr_sensor_slave #(.SILENCE_CYC(SIL), .BIT_CYC(BIT)) u_mbr_sensor_slave (
      .hclk(hclk), .hresetn(hresetn), .link(u_mbr_link_if.slave),
      .station_number(v[0][7:0]), .irradiance_compensated(v[1]),
      .irradiance_raw(v[2]), .body_temperature(v[3][15:0]),
      .element_resistance(v[4][15:0]), .irradiance_scale(v[5][15:0]),
      .temperature_scale(v[6][15:0]), .element_voltage(v[7]),
      .unit_serial(v[8][15:0]), .element_sensitivity(v[9]),
      .calibration_date(v[10]), .internal_humidity(v[11][15:0]),
      .served(served));
   mbr_logger_master #(.SILENCE_CYC(SIL), .BIT_CYC(BIT), .TIMEOUT_CYC(4000))
      u_mbr_logger_master (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .link(u_mbr_link_if.master));
   mbr_link_asserts #(.SILENCE_CYC(SIL), .BIT_CYC(BIT)) u_mbr_link_asserts (
      .hclk(hclk), .hresetn(hresetn), .m_tx(u_mbr_link_if.m_tx),
      .m_de(u_mbr_link_if.m_de), .s_tx(u_mbr_link_if.s_tx),
      .s_de(u_mbr_link_if.s_de), .line(u_mbr_link_if.line));
   always #10 hclk = ~hclk;
   function automatic logic [15:0] mreg(input logic [15:0] r);
      case (r)
         `MBR_REG_IRR_COMP: return v[1][31:16];
         16'h0004: return v[1][15:0];
         `MBR_REG_BODY_TEMP: return v[3][15:0];
         `MBR_REG_VOLTAGE: return v[7][31:16];
         16'h000C: return v[7][15:0];
         default: return 16'h0000;
      endcase
   endfunction
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0000_00, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] e);
      comparisons++;
      if (got !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Worst case about 22k cycles for the four link exchanges
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (served === 1'b1) n_srv <= n_srv + 1;
      if (cyc == 60_000) begin
         n_fail++;
         end_sim();
      end
   end
   initial begin
      lf = 32'h0001_2C62;
      for (int i = 0; i < 12; i++) begin
         lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
         v[i] <= lf;
      end
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `MBR_DATA_OFS, 32'h0, rd);
      chk(rd, `MBR_DATA_RESET);
      // Last pass uses a foreign address: no reply, data kept
      for (int t = 0; t < 4; t++) begin
         ahb(1'b1, `MBR_CMD_OFS,
             {7'h00, pr[t], v[0][7:0] + 8'(t / 3), st[t]}, rd);
         do ahb(1'b0, `MBR_STAT_OFS, 32'h0, rd); while (rd[1] !== 1'b1);
         chk({29'h0, rd[2:0]}, {29'h0, t == 3, 2'b10});
         hi = mreg(st[t]);
         lo = mreg(st[t] + 16'h0001);
         if (t < 3) exp_d = pr[t] ? {hi, lo} : {{16{hi[15]}}, hi};
         ahb(1'b0, `MBR_DATA_OFS, 32'h0, rd);
         chk(rd, exp_d);
         $display("test %0d done", t);
      end
      chk(n_srv, 32'h0000_0003);
      chk({31'h0, hresp}, 32'h0);
      end_sim();
   end
endmodule
